// ### src/adc_ctrl_pkg.sv
// constants, register map and types shared by the converter control block
package adc_ctrl_pkg;

    // ==================================================================
    // register bus
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL_MAIN = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SRC_CLK = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'hc;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==================================================================
    // converter_control_main fields
    localparam int unsigned CM_START_BIT = 7;
    localparam int unsigned CM_BUSY_BIT = 6;
    localparam int unsigned CM_PWR_BIT = 5;
    localparam int unsigned CM_FMT_BIT = 4;
    localparam int unsigned CM_CH_LSB = 0;
    localparam int unsigned CH_W = 4;
    localparam logic [7:0] CTRL_MAIN_RST = 8'h00;
    localparam logic [7:0] CTRL_MAIN_WMASK = 8'hbf;

    // ==================================================================
    // converter_source_clock_cfg fields
    localparam int unsigned SC_SRC_LSB = 5;
    localparam int unsigned SRC_W = 3;
    localparam int unsigned SC_REF_LSB = 3;
    localparam int unsigned REF_W = 2;
    localparam int unsigned SC_DIV_LSB = 0;
    localparam int unsigned DIV_W = 3;
    localparam logic [7:0] SRC_CLK_RST = 8'h00;

    // ==================================================================
    // codes
    localparam int unsigned NUM_EXT_CH = 4;
    localparam logic [SRC_W-1:0] SRC_EXT = 3'h0;
    localparam logic [SRC_W-1:0] SRC_BANDGAP = 3'h1;
    localparam logic [SRC_W-1:0] SRC_AMP0 = 3'h2;
    localparam logic [SRC_W-1:0] SRC_AMP1 = 3'h3;
    localparam logic [SRC_W-1:0] SRC_RSVD = 3'h4;
    localparam logic [REF_W-1:0] REF_SUPPLY = 2'h1;

    // ==================================================================
    // interrupt and timing
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam logic IRQ_MASK_RST = 1'b0;
    localparam int unsigned SAMPLE_CLKS = 4;
    localparam int unsigned CONVERT_CLKS = 12;

    typedef enum logic [3:0] {
        CONV_IDLE = 4'b0001,
        CONV_ARMED = 4'b0010,
        CONV_SAMPLE = 4'b0100,
        CONV_CONVERT = 4'b1000
    } conv_state_t;

endpackage : adc_ctrl_pkg

// ### src/conv_clock_divider.sv
// power-of-two divider giving one tick per converter clock period
`timescale 1ns/1ps
`default_nettype none

module conv_clock_divider #(
    parameter int unsigned SEL_W = adc_ctrl_pkg::DIV_W
) (
    input wire logic sys_clk,          // system clock
    input wire logic rst,              // synchronous reset, high
    input wire logic enable,           // run while converter is powered
    input wire logic [SEL_W-1:0] sel,  // divide by two to the power sel
    output logic tick                  // one-cycle pulse per converter clock
);
    import adc_ctrl_pkg::*;

    localparam int unsigned CW = (1 << SEL_W) - 1;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } div_state_t;

    localparam div_state_t DIV_RST = '{cnt: '0, tick: 1'b0};

    initial begin
        if (SEL_W < 1 || SEL_W > 5) begin
            $error("SEL_W out of range");
        end
    end

    div_state_t s_ff;
    div_state_t nxt_s;

    always_comb begin
        logic [CW-1:0] mask;
        mask = CW'((1 << sel) - 1);
        nxt_s = s_ff;
        if (!enable) begin
            nxt_s.cnt = '0;
            nxt_s.tick = 1'b0;
        end else begin
            nxt_s.tick = ((s_ff.cnt & mask) == mask);
            nxt_s.cnt = s_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_ff <= DIV_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign tick = s_ff.tick;

endmodule : conv_clock_divider

`default_nettype wire

// ### src/adc_input_clock_control.sv
// converter control: registers, routing and conversion sequencing
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - channel codes 0 to 3 route analog pins 0 to 3; higher codes route none
// - source 000 and 101-111 external, 001 bandgap, 010 amp0, 011 amp1, 100 reserved
// - reference 01 takes converter supply; 00 and 1x take the external pin
// - clock field divides system clock by two to the power of its code
// - a conversion starts only after the start bit goes high then low
// - busy flag reads one from successful start until conversion ends
// - at completion busy clears and the interrupt request flag sets
// - an enabled interrupt request raises the interrupt output on completion
// - converter circuitry is powered only while the power enable bit is high
// - a conversion is 4 sampling plus 12 converting clocks, 16 in total
module adc_input_clock_control #(
    parameter int unsigned SAMPLE_LEN = adc_ctrl_pkg::SAMPLE_CLKS,
    parameter int unsigned CONVERT_LEN = adc_ctrl_pkg::CONVERT_CLKS
) (
    input wire logic sys_clk,                                // system clock, 200 MHz
    input wire logic rst,                                    // synchronous reset, high
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid,                          // write address valid
    output logic s_axi_awready,                              // write address ready
    input wire logic [adc_ctrl_pkg::DATA_W-1:0] s_axi_wdata,  // write data
    input wire logic [3:0] s_axi_wstrb,                      // write byte strobes
    input wire logic s_axi_wvalid,                           // write data valid
    output logic s_axi_wready,                               // write data ready
    output logic [1:0] s_axi_bresp,                          // write response
    output logic s_axi_bvalid,                               // write response valid
    input wire logic s_axi_bready,                           // write response ready
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid,                          // read address valid
    output logic s_axi_arready,                              // read address ready
    output logic [adc_ctrl_pkg::DATA_W-1:0] s_axi_rdata,      // read data
    output logic [1:0] s_axi_rresp,                          // read response
    output logic s_axi_rvalid,                               // read data valid
    input wire logic s_axi_rready,                           // read data ready
    output logic [adc_ctrl_pkg::NUM_EXT_CH-1:0] analog_pin_en, // analog pin switches
    output logic ext_path_sel,                               // external channel feeds converter
    output logic bandgap_reference_sel,                      // bandgap feeds converter
    output logic amp0_output_sel,                            // amplifier 0 feeds converter
    output logic amp1_output_sel,                            // amplifier 1 feeds converter
    output logic ref_supply_sel,                             // reference from supply
    output logic ref_pin_sel,                                // reference from external pin
    output logic converter_power,                            // analog power switch
    output logic data_format,                                // result format bit
    output logic sample_active,                              // sampling phase
    output logic convert_active,                             // conversion phase
    output logic conversion_busy_flag,                       // conversion under way
    output logic conv_done,                                  // one-cycle completion pulse
    output logic irq                                         // level interrupt
);
    import adc_ctrl_pkg::*;

    localparam int unsigned CNT_W = $clog2((SAMPLE_LEN > CONVERT_LEN ? SAMPLE_LEN : CONVERT_LEN) + 1);
    localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_LEN - 1);
    localparam logic [CNT_W-1:0] CONVERT_LAST = CNT_W'(CONVERT_LEN - 1);

    initial begin
        if (SAMPLE_LEN < 1 || CONVERT_LEN < 1) begin
            $error("phase lengths must be at least one");
        end
    end

    // ==================================================================
    // state
    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [7:0] wbyte;
        logic wlane;
        logic [7:0] ctrl_main;
        logic [7:0] src_clk;
        logic irq_status;
        logic irq_mask;
        conv_state_t cst;
        logic [CNT_W-1:0] cnt;
        logic [NUM_EXT_CH-1:0] pin_en;
        logic ext_sel;
        logic bg_sel;
        logic a0_sel;
        logic a1_sel;
        logic rsup;
        logic rpin;
        logic pwr;
        logic fmt;
        logic smp;
        logic cnv;
        logic busy;
        logic done;
        logic irq;
    } ctl_state_t;

    localparam ctl_state_t CTL_RST = '{
        bresp: RESP_OKAY,
        rresp: RESP_OKAY,
        ctrl_main: CTRL_MAIN_RST,
        src_clk: SRC_CLK_RST,
        irq_mask: IRQ_MASK_RST,
        cst: CONV_IDLE,
        default: '0
    };

    ctl_state_t s_ff;
    ctl_state_t nxt_s;
    logic tick;

    // ==================================================================
    // decode helpers
    function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
        reg_sel = 4'h0;
        unique case (a)
            OFS_CTRL_MAIN: reg_sel = 4'h1;
            OFS_SRC_CLK: reg_sel = 4'h2;
            OFS_IRQ_STATUS: reg_sel = 4'h4;
            OFS_IRQ_MASK: reg_sel = 4'h8;
            default: reg_sel = 4'h0;
        endcase
    endfunction : reg_sel

    function automatic logic [NUM_EXT_CH-1:0] pin_decode(input logic [CH_W-1:0] ch);
        pin_decode = '0;
        if (ch < CH_W'(NUM_EXT_CH)) begin
            pin_decode[ch[$clog2(NUM_EXT_CH)-1:0]] = 1'b1;
        end
    endfunction : pin_decode

    // ==================================================================
    // converter clock
    conv_clock_divider #(
        .SEL_W(DIV_W)
    ) u_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(s_ff.pwr),
        .sel(s_ff.src_clk[SC_DIV_LSB +: DIV_W]),
        .tick(tick)
    );

    // ==================================================================
    // next state
    always_comb begin
        logic [3:0] wsel;
        logic [3:0] rsel;
        logic irq_clr;
        logic start_fall;
        logic done_evt;
        logic [SRC_W-1:0] src;
        logic [7:0] rbyte;
        wsel = 4'h0;
        rsel = 4'h0;
        irq_clr = 1'b0;
        start_fall = 1'b0;
        done_evt = 1'b0;
        src = '0;
        rbyte = 8'h00;
        nxt_s = s_ff;

        // write channel
        if (s_axi_awvalid && s_ff.awready) begin
            nxt_s.aw_got = 1'b1;
            nxt_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_ff.wready) begin
            nxt_s.w_got = 1'b1;
            nxt_s.wbyte = s_axi_wdata[7:0];
            nxt_s.wlane = s_axi_wstrb[0];
        end
        if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
            wsel = reg_sel(s_ff.awaddr);
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = (wsel == 4'h0) ? RESP_SLVERR : RESP_OKAY;
            if (s_ff.wlane) begin
                if (wsel[0]) begin
                    nxt_s.ctrl_main = s_ff.wbyte & CTRL_MAIN_WMASK;
                end
                if (wsel[1]) begin
                    nxt_s.src_clk = s_ff.wbyte;
                end
                if (wsel[2]) begin
                    irq_clr = s_ff.wbyte[IRQ_DONE_BIT];
                end
                if (wsel[3]) begin
                    nxt_s.irq_mask = s_ff.wbyte[IRQ_DONE_BIT];
                end
            end
        end
        if (s_ff.bvalid && s_axi_bready) begin
            nxt_s.bvalid = 1'b0;
        end
        nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
        nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;

        // read channel
        if (s_axi_arvalid && s_ff.arready) begin
            rsel = reg_sel(s_axi_araddr);
            if (rsel[0]) begin
                rbyte = s_ff.ctrl_main;
                rbyte[CM_BUSY_BIT] = s_ff.busy;
            end
            if (rsel[1]) begin
                rbyte = s_ff.src_clk;
            end
            if (rsel[2]) begin
                rbyte[IRQ_DONE_BIT] = s_ff.irq_status;
            end
            if (rsel[3]) begin
                rbyte[IRQ_DONE_BIT] = s_ff.irq_mask;
            end
            nxt_s.rvalid = 1'b1;
            nxt_s.rdata = {{(DATA_W-8){1'b0}}, rbyte};
            nxt_s.rresp = (rsel == 4'h0) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_ff.rvalid && s_axi_rready) begin
            nxt_s.rvalid = 1'b0;
        end
        nxt_s.arready = !nxt_s.rvalid;

        // conversion sequence
        start_fall = s_ff.ctrl_main[CM_START_BIT] && !nxt_s.ctrl_main[CM_START_BIT];
        unique case (s_ff.cst)
            CONV_IDLE: begin
                nxt_s.cnt = '0;
                if (start_fall && nxt_s.ctrl_main[CM_PWR_BIT]) begin
                    nxt_s.cst = CONV_ARMED;
                end
            end
            CONV_ARMED: begin
                if (tick) begin
                    nxt_s.cst = CONV_SAMPLE;
                end
            end
            CONV_SAMPLE: begin
                if (tick) begin
                    if (s_ff.cnt == SAMPLE_LAST) begin
                        nxt_s.cst = CONV_CONVERT;
                        nxt_s.cnt = '0;
                    end else begin
                        nxt_s.cnt = s_ff.cnt + 1'b1;
                    end
                end
            end
            CONV_CONVERT: begin
                if (tick) begin
                    if (s_ff.cnt == CONVERT_LAST) begin
                        nxt_s.cst = CONV_IDLE;
                        nxt_s.cnt = '0;
                        done_evt = 1'b1;
                    end else begin
                        nxt_s.cnt = s_ff.cnt + 1'b1;
                    end
                end
            end
            default: begin
                nxt_s.cst = CONV_IDLE;
                nxt_s.cnt = '0;
            end
        endcase
        // losing power abandons a conversion without completion
        if (!nxt_s.ctrl_main[CM_PWR_BIT]) begin
            nxt_s.cst = CONV_IDLE;
            nxt_s.cnt = '0;
            done_evt = 1'b0;
        end

        // interrupt: completion wins over a same-cycle clear
        nxt_s.irq_status = (s_ff.irq_status & !irq_clr) | done_evt;
        nxt_s.irq = nxt_s.irq_status && nxt_s.irq_mask;
        nxt_s.done = done_evt;
        nxt_s.busy = (nxt_s.cst != CONV_IDLE);
        nxt_s.smp = (nxt_s.cst == CONV_SAMPLE);
        nxt_s.cnv = (nxt_s.cst == CONV_CONVERT);

        // routing
        src = nxt_s.src_clk[SC_SRC_LSB +: SRC_W];
        nxt_s.pin_en = pin_decode(nxt_s.ctrl_main[CM_CH_LSB +: CH_W]);
        nxt_s.ext_sel = (src == SRC_EXT) || (src > SRC_RSVD);
        nxt_s.bg_sel = (src == SRC_BANDGAP);
        nxt_s.a0_sel = (src == SRC_AMP0);
        nxt_s.a1_sel = (src == SRC_AMP1);
        nxt_s.rsup = (nxt_s.src_clk[SC_REF_LSB +: REF_W] == REF_SUPPLY);
        nxt_s.rpin = !nxt_s.rsup;
        nxt_s.pwr = nxt_s.ctrl_main[CM_PWR_BIT];
        nxt_s.fmt = nxt_s.ctrl_main[CM_FMT_BIT];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_ff <= CTL_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ==================================================================
    // outputs
    assign s_axi_awready = s_ff.awready;
    assign s_axi_wready = s_ff.wready;
    assign s_axi_bvalid = s_ff.bvalid;
    assign s_axi_bresp = s_ff.bresp;
    assign s_axi_arready = s_ff.arready;
    assign s_axi_rvalid = s_ff.rvalid;
    assign s_axi_rdata = s_ff.rdata;
    assign s_axi_rresp = s_ff.rresp;
    assign analog_pin_en = s_ff.pin_en;
    assign ext_path_sel = s_ff.ext_sel;
    assign bandgap_reference_sel = s_ff.bg_sel;
    assign amp0_output_sel = s_ff.a0_sel;
    assign amp1_output_sel = s_ff.a1_sel;
    assign ref_supply_sel = s_ff.rsup;
    assign ref_pin_sel = s_ff.rpin;
    assign converter_power = s_ff.pwr;
    assign data_format = s_ff.fmt;
    assign sample_active = s_ff.smp;
    assign convert_active = s_ff.cnv;
    assign conversion_busy_flag = s_ff.busy;
    assign conv_done = s_ff.done;
    assign irq = s_ff.irq;

endmodule : adc_input_clock_control

`default_nettype wire

// ### sim/adc_ctrl_monitor.sv
// checker watching the converter control block ports
`timescale 1ns/1ps
`default_nettype none

module adc_ctrl_monitor (
    input wire logic sys_clk, // clock
    input wire logic rst, // reset
    input wire logic [adc_ctrl_pkg::NUM_EXT_CH-1:0] analog_pin_en, // pin switches
    input wire logic ext_path_sel, // external path
    input wire logic bandgap_reference_sel, // bandgap path
    input wire logic amp0_output_sel, // amp 0 path
    input wire logic amp1_output_sel, // amp 1 path
    input wire logic ref_supply_sel, // supply reference
    input wire logic ref_pin_sel, // pin reference
    input wire logic converter_power, // power switch
    input wire logic sample_active, // sampling
    input wire logic convert_active, // converting
    input wire logic conversion_busy_flag, // busy
    input wire logic conv_done // completion pulse
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // ==================================================================
    // routing
    ref_exclusive_a: assert property (!$past(rst) |-> ref_supply_sel != ref_pin_sel)
        else $error("reference selects not exclusive");
    source_onehot_a: assert property ($onehot0({ext_path_sel, bandgap_reference_sel,
        amp0_output_sel, amp1_output_sel})) else $error("several sources routed");
    pin_onehot_a: assert property ($onehot0(analog_pin_en))
        else $error("several analog pins routed");

    // ==================================================================
    // sequencing
    done_single_a: assert property (conv_done |=> !conv_done)
        else $error("completion pulse longer than one cycle");
    done_clears_busy_a: assert property (conv_done |->
        !conversion_busy_flag && $past(conversion_busy_flag))
        else $error("busy not cleared at completion");
    phase_busy_a: assert property ((sample_active || convert_active) |->
        conversion_busy_flag && !(sample_active && convert_active))
        else $error("phase active without busy");
    power_abort_a: assert property ($fell(converter_power) |-> ##1
        !conversion_busy_flag && !sample_active && !convert_active)
        else $error("conversion runs without power");
    sample_to_convert_a: assert property ($fell(sample_active) && converter_power |->
        convert_active) else $error("sampling not followed by conversion");
    sample_min_a: assert property ($rose(sample_active) |-> sample_active[*4])
        else $error("sampling shorter than four clocks");
    convert_end_a: assert property ($fell(convert_active) |-> conv_done || !converter_power)
        else $error("conversion ended without completion");
endmodule : adc_ctrl_monitor

bind adc_input_clock_control adc_ctrl_monitor u_mon (.sys_clk(sys_clk), .rst(rst),
    .analog_pin_en(analog_pin_en), .ext_path_sel(ext_path_sel),
    .bandgap_reference_sel(bandgap_reference_sel), .amp0_output_sel(amp0_output_sel),
    .amp1_output_sel(amp1_output_sel), .ref_supply_sel(ref_supply_sel),
    .ref_pin_sel(ref_pin_sel), .converter_power(converter_power),
    .sample_active(sample_active), .convert_active(convert_active),
    .conversion_busy_flag(conversion_busy_flag), .conv_done(conv_done));

`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import adc_ctrl_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf, pins;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, ext_sel, bg_sel, a0_sel, a1_sel;
    logic ref_sup, ref_pin, pwr, fmt, smp, cnv, busy, done, irq;
    logic [1:0] bresp, rresp;
    logic [4:0] hs;
    int error_cnt = 0, num_checks = 0, n_smp = 0, n_cnv = 0, n_done = 0;
    integer seed = 32'h2d1a;

    always #2.5 sys_clk = ~sys_clk;

    always @(negedge sys_clk) begin
        hs <= {awready, wready, bvalid, arready, rvalid};
        if (smp === 1'b1) n_smp++;
        if (cnv === 1'b1) n_cnv++;
        if (done === 1'b1) n_done++;
    end

    adc_input_clock_control #(.SAMPLE_LEN(SAMPLE_CLKS), .CONVERT_LEN(CONVERT_CLKS)) DUT (
        .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .analog_pin_en(pins), .ext_path_sel(ext_sel), .bandgap_reference_sel(bg_sel),
        .amp0_output_sel(a0_sel), .amp1_output_sel(a1_sel), .ref_supply_sel(ref_sup),
        .ref_pin_sel(ref_pin), .converter_power(pwr), .data_format(fmt),
        .sample_active(smp), .convert_active(cnv), .conversion_busy_flag(busy),
        .conv_done(done), .irq(irq));

    // ==================================================================
    // checking and report
    task automatic chk_bit(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    task automatic step(inout int n);
        @(posedge sys_clk);
        n++;
        if (n > 4000) begin
            error_cnt++;
            $display("Error wait expected end seen timeout");
            summarize();
        end
    endtask : step

    // ==================================================================
    // register bus master
    task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            step(n);
            if (!aw_ok && hs[4] === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && hs[3] === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do step(n); while (hs[2] !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do step(n); while (hs[1] !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do step(n); while (hs[0] !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk_word(nm, e, d);
    endtask : rchk

    // ==================================================================
    // expectations
    function automatic logic [3:0] exp_pins(input logic [3:0] ch);
        return (ch < 4'h4) ? (4'h1 << ch) : 4'h0;
    endfunction : exp_pins

    // order: external, bandgap, amp0, amp1
    function automatic logic [3:0] exp_src(input logic [2:0] s);
        case (s)
            3'h1: return 4'h4;
            3'h2: return 4'h2;
            3'h3: return 4'h1;
            3'h4: return 4'h0;
            default: return 4'h8;
        endcase
    endfunction : exp_src

    // ==================================================================
    // scenarios
    initial begin
        logic [31:0] v;
        logic [1:0] r;
        logic [7:0] ctl, cfg;
        int s0, c0, d0, n;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk_bit("ref_pin_sel", 1'b1, ref_pin);
        for (int i = 0; i < 4; i++) rchk("reset value", 4'(4 * i), 32'h0);
        wr(4'h2, 8'hff, r);
        chk_word("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        rd(4'h2, v, r);
        chk_word("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            ctl = {3'h0, 1'($random(seed)), i[3] | (i[2] & (|i[1:0])), i[2:0]};
            cfg = {3'(i + 4), 2'($random(seed)), 3'($random(seed))};
            wr(OFS_CTRL_MAIN, ctl, r);
            wr(OFS_SRC_CLK, cfg, r);
            chk_word("pins", {28'h0, exp_pins(ctl[3:0])}, {28'h0, pins});
            chk_word("source", {28'h0, exp_src(cfg[7:5])}, {28'h0, ext_sel, bg_sel, a0_sel, a1_sel});
            chk_bit("ref_supply_sel", cfg[4:3] == 2'b01, ref_sup);
            chk_bit("ref_pin_sel", cfg[4:3] != 2'b01, ref_pin);
            chk_bit("data_format", ctl[4], fmt);
        end
        wstrb <= 4'h0;
        wr(OFS_SRC_CLK, 8'h00, r);
        wstrb <= 4'hf;
        rchk("strobe off", OFS_SRC_CLK, {24'h0, cfg});
        $display("test routing done");
        for (int d = 0; d < 8; d++) begin
            wr(OFS_SRC_CLK, 8'(d), r);
            wr(OFS_IRQ_MASK, {7'h0, 1'(d)}, r);
            wr(OFS_CTRL_MAIN, 8'ha0, r);
            s0 = n_smp;
            c0 = n_cnv;
            d0 = n_done;
            wr(OFS_CTRL_MAIN, 8'h20, r);
            chk_bit("busy", 1'b1, busy);
            n = 0;
            while (busy === 1'b1) step(n);
            step(n);
            chk_word("sample clocks", SAMPLE_CLKS << d, n_smp - s0);
            chk_word("convert clocks", CONVERT_CLKS << d, n_cnv - c0);
            chk_word("done pulses", 1, n_done - d0);
            chk_bit("irq", d[0], irq);
            rchk("status", OFS_IRQ_STATUS, 32'h1);
            rchk("busy readback", OFS_CTRL_MAIN, 32'h20);
            wr(OFS_IRQ_MASK, 8'h01, r);
            chk_bit("irq unmasked", 1'b1, irq);
            wr(OFS_IRQ_STATUS, 8'h01, r);
            chk_bit("irq cleared", 1'b0, irq);
            rchk("status cleared", OFS_IRQ_STATUS, 32'h0);
        end
        $display("test conversions done");
        wr(OFS_CTRL_MAIN, 8'ha0, r);
        repeat (4) @(posedge sys_clk);
        chk_bit("busy start held", 1'b0, busy);
        wr(OFS_CTRL_MAIN, 8'h80, r);
        wr(OFS_CTRL_MAIN, 8'h00, r);
        chk_bit("converter_power", 1'b0, pwr);
        chk_bit("busy unpowered", 1'b0, busy);
        $display("test start pulse done");
        wr(OFS_SRC_CLK, 8'h07, r);
        d0 = n_done;
        wr(OFS_CTRL_MAIN, 8'ha0, r);
        chk_bit("converter_power", 1'b1, pwr);
        wr(OFS_CTRL_MAIN, 8'h20, r);
        chk_bit("busy", 1'b1, busy);
        wr(OFS_CTRL_MAIN, 8'h00, r);
        chk_bit("busy aborted", 1'b0, busy);
        chk_word("done pulses", d0, n_done);
        rchk("status aborted", OFS_IRQ_STATUS, 32'h0);
        $display("test abort done");
        summarize();
    end
endmodule : tb_top

`default_nettype wire
